// ### mpk_consts.vh
`ifndef MPK_CONSTS_VH
`define MPK_CONSTS_VH
// ----------------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------------
`define MPK_CLK_HZ          20000000
// Durations in milliseconds, as specified
`define MPK_START_MS        2000
`define MPK_SHUT_MS         2500
`define MPK_RESTART_MS      1000
`define MPK_SHUTDOWN_MS     3000
// Cycle counts derived from the rate
`define MPK_MS_CYC(ms)      ((ms) * (`MPK_CLK_HZ / 1000))
// ----------------------------------------------------------------------
// Internal step length (cycles) and counter width (bits)
// ----------------------------------------------------------------------
`define MPK_INIT_CYC        1000
`define MPK_CNT_W           32
`endif

// ### mpk_pulse_timer.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Low-pulse qualifier: counts while the pin stays low, fires once
// ----------------------------------------------------------------------
module mpk_pulse_timer #(
  parameter [31:0] LIMIT = 32'h0000_0010
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire arm_i,
  input  wire pin_n_i,
  output wire fire_o
);
  reg [31:0] cnt_q;
  reg        done_q;

  // Restart count on any high sample; short pulses never reach LIMIT
  always @(posedge clk_i) begin
    if (rst_i || pin_n_i || !arm_i) begin
      cnt_q  <= 32'h0000_0000;
      done_q <= 1'b0;
    end else if (!done_q) begin
      if (cnt_q == LIMIT - 32'h0000_0001) begin
        done_q <= 1'b1;
      end
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  // One pulse per continuous low stretch
  assign fire_o = arm_i && !pin_n_i && !done_q && (cnt_q == LIMIT - 32'h0000_0001);
endmodule

// ### mpk_sequencer.v
`timescale 1ns/1ps
`include "mpk_consts.vh"
module mpk_sequencer #(
  parameter [31:0] START_CYC    = `MPK_MS_CYC(`MPK_START_MS),
  parameter [31:0] SHUT_CYC     = `MPK_MS_CYC(`MPK_SHUT_MS),
  parameter [31:0] RESTART_CYC  = `MPK_MS_CYC(`MPK_RESTART_MS),
  parameter [31:0] SHUTDOWN_CYC = `MPK_MS_CYC(`MPK_SHUTDOWN_MS),
  parameter [31:0] INIT_CYC     = `MPK_INIT_CYC
) (
  input  wire MCLK_I,
  input  wire RESET_I,
  input  wire POWER_KEY_N_I,
  input  wire RESTART_N_I,
  input  wire AUTO_START_I,
  input  wire AT_SEEN_I,
  output wire STATUS_O,
  output wire IO_RAIL_OUT_O,
  output wire READY_BANNER_O,
  output wire BAUD_LOCK_O,
  output wire SHUTTING_DOWN_O
);
  // ----------------------------------------------------------------------
  // States (one-hot)
  // ----------------------------------------------------------------------
  localparam [5:0] ST_OFF  = 6'b000001;
  localparam [5:0] ST_INIT = 6'b000010;
  localparam [5:0] ST_BAUD = 6'b000100;
  localparam [5:0] ST_RUN  = 6'b001000;
  localparam [5:0] ST_SHUT = 6'b010000;
  localparam [5:0] ST_RST  = 6'b100000;

  // ----------------------------------------------------------------------
  // State decodes
  // ----------------------------------------------------------------------
  // Initialised states: status lamp lit, restart qualifier armed, shutdown qualifier too unless auto-start strapped
  function is_ready;
    input [5:0] st;
    begin
      is_ready = (st == ST_BAUD) || (st == ST_RUN);
    end
  endfunction

  // Rail stays up through shutdown; only off and restart drop it
  function is_powered;
    input [5:0] st;
    begin
      is_powered = (st != ST_OFF) && (st != ST_RST);
    end
  endfunction

  // Sequencer state, dwell timer and output flops
  reg [5:0]  state_q;
  reg [5:0]  state_d;
  reg [31:0] tmr_q;
  reg [31:0] tmr_d;
  reg        status_q;
  reg        rail_q;
  reg        banner_q;
  reg        lock_q;
  reg        auto_q;
  reg        strap_q;
  reg        shut_q;
  // Ready decode, then qualifier fire strobes of one cycle each
  wire       run_st;
  wire       start_fire;
  wire       shut_fire;
  wire       rst_fire;

  // ----------------------------------------------------------------------
  // Pin qualifiers
  // ----------------------------------------------------------------------
  // Shutdown and restart only count once the module is initialised
  assign run_st = is_ready(state_q);

  // Start qualifier armed only while off
  mpk_pulse_timer #(.LIMIT(START_CYC)) u_start (
    .clk_i   (MCLK_I),
    .rst_i   (RESET_I),
    .arm_i   (state_q == ST_OFF),
    .pin_n_i (POWER_KEY_N_I),
    .fire_o  (start_fire)
  );

  // Shutdown key disarmed under auto-start tie
  mpk_pulse_timer #(.LIMIT(SHUT_CYC + 32'h0000_0001)) u_shut (
    .clk_i   (MCLK_I),
    .rst_i   (RESET_I),
    .arm_i   (run_st && !strap_q),
    .pin_n_i (POWER_KEY_N_I),
    .fire_o  (shut_fire)
  );

  // More than the limit means one sample past it
  mpk_pulse_timer #(.LIMIT(RESTART_CYC + 32'h0000_0001)) u_rst (
    .clk_i   (MCLK_I),
    .rst_i   (RESET_I),
    .arm_i   (run_st),
    .pin_n_i (RESTART_N_I),
    .fire_o  (rst_fire)
  );

  // ----------------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------------
  // Later strap changes are ignored until the next reset
  always @(posedge MCLK_I) begin
    if (RESET_I) begin
      auto_q  <= 1'b0;
      strap_q <= 1'b0;
    end else if (!auto_q) begin
      auto_q  <= 1'b1;
      strap_q <= AUTO_START_I; // Sampled once, held until reset
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------------
  always @* begin
    state_d = state_q;
    tmr_d   = tmr_q + 32'h0000_0001;
    case (state_q)
      ST_OFF: begin
        tmr_d = 32'h0000_0000;
        // Auto-start ties the key low, so it starts like a held key;
        // the strap only takes away key shutdown, it never starts alone
        if (start_fire) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        // Boot dwell; the status lamp lights as baud search begins
        if (tmr_q == INIT_CYC - 32'h0000_0001) begin
          state_d = ST_BAUD;
          tmr_d   = 32'h0000_0000;
        end
      end
      ST_BAUD: begin
        // No timeout: the host must send AT before any data
        if (AT_SEEN_I) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        // Timer parked while running
        tmr_d = 32'h0000_0000;
      end
      ST_SHUT: begin
        // Rail held up until the power-down dwell runs out
        if (tmr_q == SHUTDOWN_CYC - 32'h0000_0001) begin
          state_d = ST_OFF;
        end
      end
      ST_RST: begin
        // One cycle of rail drop, then reinitialise
        state_d = ST_INIT;
        tmr_d   = 32'h0000_0000;
      end
      default: begin
        // Broken one-hot code falls back to off
        state_d = ST_OFF;
        tmr_d   = 32'h0000_0000;
      end
    endcase
    // Shutdown outranks restart when both qualify together
    if (shut_fire) begin
      state_d = ST_SHUT;
      tmr_d   = 32'h0000_0000;
    end else if (rst_fire) begin
      state_d = ST_RST;
      tmr_d   = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // State and output registers
  // ----------------------------------------------------------------------
  // Outputs follow the next state so they change with it, not a cycle late
  always @(posedge MCLK_I) begin
    if (RESET_I) begin
      state_q  <= ST_OFF;
      tmr_q    <= 32'h0000_0000;
      status_q <= 1'b0;
      rail_q   <= 1'b0;
      banner_q <= 1'b0;
      lock_q   <= 1'b0;
      shut_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      tmr_q    <= tmr_d;
      status_q <= is_ready(state_d);
      rail_q   <= is_powered(state_d);
      // Banner pulse rises with baud lock on the same edge; repeats after every restart
      banner_q <= (state_q == ST_BAUD) && (state_d == ST_RUN);
      lock_q   <= (state_d == ST_RUN);
      shut_q   <= (state_d == ST_SHUT);
    end
  end

  // ----------------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------------
  // Every output straight from a flop, no decode glitches at the pins
  assign STATUS_O        = status_q;
  assign IO_RAIL_OUT_O   = rail_q;
  assign READY_BANNER_O  = banner_q;
  assign BAUD_LOCK_O     = lock_q;
  assign SHUTTING_DOWN_O = shut_q;
endmodule

// ### mpk_props.sv
`timescale 1ns/1ps
module mpk_props #(
  parameter int START_CYC    = 20,
  parameter int SHUT_CYC     = 25,
  parameter int INIT_CYC     = 5,
  parameter int SHUTDOWN_CYC = 30
) (
  input wire MCLK_I,
  input wire RESET_I,
  input wire POWER_KEY_N_I,
  input wire RESTART_N_I,
  input wire AUTO_START_I,
  input wire AT_SEEN_I,
  input wire STATUS_O,
  input wire IO_RAIL_OUT_O,
  input wire READY_BANNER_O,
  input wire BAUD_LOCK_O,
  input wire SHUTTING_DOWN_O
);
  reg [31:0] low_q;
  // Key low run, cleared by any high sample
  always @(posedge MCLK_I) low_q <= (RESET_I | POWER_KEY_N_I) ? 0 : low_q + 1;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  rail_on_a: assert property (STATUS_O |-> IO_RAIL_OUT_O) else $error("rail");
  ban_pulse_a: assert property (READY_BANNER_O |=> !READY_BANNER_O) else $error("ban");
  ban_cause_a: assert property (READY_BANNER_O |-> $past(AT_SEEN_I) && STATUS_O)
    else $error("cause");
  init_time_a: assert property ($rose(IO_RAIL_OUT_O) |-> !STATUS_O ##INIT_CYC STATUS_O)
    else $error("init");
  shut_time_a: assert property ($rose(SHUTTING_DOWN_O) |->
    ##SHUTDOWN_CYC !SHUTTING_DOWN_O) else $error("shut");
  rail_off_a: assert property ($rose(SHUTTING_DOWN_O) |-> IO_RAIL_OUT_O
    ##SHUTDOWN_CYC !IO_RAIL_OUT_O) else $error("off");
  rst_drop_a: assert property ($fell(IO_RAIL_OUT_O) && !$past(SHUTTING_DOWN_O)
    |=> IO_RAIL_OUT_O) else $error("drop");
  shut_quiet_a: assert property (SHUTTING_DOWN_O |-> !STATUS_O && !BAUD_LOCK_O)
    else $error("quiet");
  shut_cause_a: assert property ($rose(SHUTTING_DOWN_O) |->
    low_q > SHUT_CYC && !AUTO_START_I) else $error("key");
  start_cause_a: assert property ($rose(IO_RAIL_OUT_O) |->
    low_q >= START_CYC || $past(IO_RAIL_OUT_O, 2)) else $error("start");
  cover property (READY_BANNER_O);
  cover property ($rose(SHUTTING_DOWN_O));
  cover property ($fell(STATUS_O) && !SHUTTING_DOWN_O);
endmodule

// ### mpk_host.sv
`timescale 1ns/1ps
module mpk_host (
  input  wire       clk_i,
  input  wire       ld_i,
  input  wire [7:0] kl_i,
  input  wire [7:0] rl_i,
  output wire       key_n_o,
  output wire       rst_n_o
);
  reg [7:0] kc_q = 0;
  reg [7:0] rc_q = 0;
  // Hold each pin low for its length, then release it high
  always @(posedge clk_i) begin
    kc_q <= ld_i ? kl_i : kc_q - (kc_q != 0);
    rc_q <= ld_i ? rl_i : rc_q - (rc_q != 0);
  end
  assign key_n_o = kc_q == 0;
  assign rst_n_o = rc_q == 0;
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  reg        c = 0, r = 1, ld = 0, as = 0, at = 0;
  reg [7:0]  kl = 0, rl = 0, n;
  reg [31:0] s = 32'h2c0d;
  wire       kn, rn, st, io, bn, lk, sd;
  integer    bad_count = 0, check_count = 0, nb = 0;
  always #25 c = ~c;
  // Count banners so repeats are seen
  always @(posedge c) nb <= nb + (bn === 1'b1);
  mpk_sequencer #(.START_CYC(20), .SHUT_CYC(25), .RESTART_CYC(10), .SHUTDOWN_CYC(30),
    .INIT_CYC(5)) dut_u (.MCLK_I(c), .RESET_I(r), .POWER_KEY_N_I(kn),
    .RESTART_N_I(rn), .AUTO_START_I(as), .AT_SEEN_I(at), .STATUS_O(st), .IO_RAIL_OUT_O(io),
    .READY_BANNER_O(bn), .BAUD_LOCK_O(lk), .SHUTTING_DOWN_O(sd));
  mpk_host host_u (.clk_i(c), .ld_i(ld), .kl_i(kl), .rl_i(rl), .key_n_o(kn), .rst_n_o(rn));
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function q(input integer len, lim);
    q = len > lim;
  endfunction
  task chk(input g, e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("ERROR %0t mismatch", $time);
      end
    end
  endtask
  // Hand the host one pulse pair; returns on the edge that drops the load
  task load(input [7:0] k, p);
    begin
      @(posedge c);
      kl <= k;
      rl <= p;
      ld <= 1;
      @(posedge c);
      ld <= 0;
    end
  endtask
  // Long settle so every count has run out
  task go(input [7:0] k, p);
    begin
      load(k, p);
      repeat (80) @(posedge c);
      #1;
    end
  endtask
  task pat;
    begin
      @(posedge c);
      at <= 1;
      @(posedge c);
      at <= 0;
      repeat (3) @(posedge c);
      #1;
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    bad_count = bad_count + 1;
    test_done;
  end
  initial begin
    repeat (8) @(posedge c);
    r <= 0;
    s = nx(s);
    n = s % 19 + 1;
    go(n, 0);
    chk(io, q(n, 19));
    go(24, 0);
    chk(io, 1);
    chk(st, 1);
    pat;
    chk(lk, 1);
    chk(nb == 1, 1);
    s = nx(s);
    n = s % 10 + 1;
    go(0, n);
    chk(lk, !q(n, 10));
    go(0, 14);
    chk(lk, 0);
    pat;
    chk(nb == 2, 1);
    go(25, 0);
    chk(st, 1);
    load(30, 0);
    repeat (40) @(posedge c);
    #1;
    chk(sd, 1);
    chk(st, 0);
    chk(io, 1);
    repeat (40) @(posedge c);
    #1;
    chk(sd, 0);
    chk(io, 0);
    @(posedge c);
    r <= 1;
    as <= 1;
    repeat (8) @(posedge c);
    r <= 0;
    go(24, 0);
    chk(io, 1);
    go(40, 0);
    chk(io, 1);
    chk(sd, 0);
    test_done;
  end
endmodule
bind mpk_sequencer mpk_props #(.START_CYC(START_CYC), .SHUT_CYC(SHUT_CYC),
  .INIT_CYC(INIT_CYC), .SHUTDOWN_CYC(SHUTDOWN_CYC)) chk_u (.MCLK_I(MCLK_I),
  .RESET_I(RESET_I), .POWER_KEY_N_I(POWER_KEY_N_I), .RESTART_N_I(RESTART_N_I),
  .AUTO_START_I(AUTO_START_I), .AT_SEEN_I(AT_SEEN_I), .STATUS_O(STATUS_O),
  .IO_RAIL_OUT_O(IO_RAIL_OUT_O), .READY_BANNER_O(READY_BANNER_O),
  .BAUD_LOCK_O(BAUD_LOCK_O), .SHUTTING_DOWN_O(SHUTTING_DOWN_O));
